// >>> verilog/qlh_device.sv
// Device end of the quad line host bus port
//
// Overview of operation
// (RL1) Two straps pick one of four styles
// (RL2) Mode 1: strobe, direction, separate address, ack
// (RL3) Mode 2: strobe, direction, shared bus, ack
// (RL4) Mode 3: read/write strobes, separate address, ready
// (RL5) Mode 4: read/write strobes, shared bus, ready
// (RL6) Direction high reads, low writes
// (RL7) Same pins every mode, interrupt active high
// (RL8) Ready high on completion, floats without select
// (RL9) Acknowledge low on completion
// (RL10) Shared bus low nibble is register index
// (RL11) Internal select matches bits six to four
// (RL12) Drive shared bus only during selected read
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module qlh_device
    import qlh_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                ce,
    // Host pins
    qlh_bus_if.device                bus,
    // Board straps of the device address
    input  wire logic [INDEX_W-1:0]  dev_addr_strap,
    // Done and interrupt alignment to the host clock
    input  wire logic                align_host_clock,
    // Register bank side
    input  wire logic                alarm_irq,
    output logic                     reg_wr,
    output logic                     reg_rd,
    output logic [INDEX_W-1:0]       reg_index,
    output logic [DATA_W-1:0]        reg_wdata,
    input  wire logic [DATA_W-1:0]   reg_rdata
);

    typedef enum logic [1:0] {D_IDLE, D_FETCH, D_ACK} qlh_dev_state_t;

    // ******************************************************
    // Pin synchronisers
    // ******************************************************
    logic [5:0]          ctl_meta;
    logic [5:0]          ctl_s;
    logic [INDEX_W-1:0]  addr_meta;
    logic [INDEX_W-1:0]  addr_s;
    logic [DATA_W-1:0]   ad_meta;
    logic [DATA_W-1:0]   ad_s;
    logic [1:0]          hclk_meta;
    logic                hclk_prev;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_meta  <= DEV_CTL_RESET;
            ctl_s     <= DEV_CTL_RESET;
            addr_meta <= '0;
            addr_s    <= '0;
            ad_meta   <= AD_IDLE;
            ad_s      <= AD_IDLE;
        end else if (ce) begin
            ctl_meta  <= {bus.bus_style_select, bus.addr_data_share_select, bus.cs_n,
                          bus.latch_or_strobe_pin, bus.store_or_strobe_pin,
                          bus.read_or_dir_pin};
            ctl_s     <= ctl_meta;
            addr_meta <= bus.addr;
            addr_s    <= addr_meta;
            ad_meta   <= bus.ad;
            ad_s      <= ad_meta;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hclk_meta <= 2'h0;
            hclk_prev <= 1'b0;
        end else if (ce) begin
            hclk_meta <= {hclk_meta[0], bus.host_clock};
            hclk_prev <= hclk_meta[1];
        end
    end

    // ******************************************************
    // Pin meaning by mode
    // ******************************************************
    logic        style;
    logic        share;
    logic        cs_n_s;
    logic        latch_s;
    logic        store_s;
    logic        rdir_s;
    logic        hclk_rise;

    // (RL1) straps pick style
    assign style     = ctl_s[5];
    assign share     = ctl_s[4];
    assign cs_n_s    = ctl_s[3];
    assign latch_s   = ctl_s[2];
    assign store_s   = ctl_s[1];
    assign rdir_s    = ctl_s[0];
    assign hclk_rise = hclk_meta[1] & ~hclk_prev;

    // Strobe active for the current style
    function automatic logic strobe_on(input logic sty, input logic st, input logic rd);
        // (RL4) separate read write strobes
        if (sty == QLH_RD_WR) begin
            strobe_on = ~st | ~rd;
        end else begin
            // (RL2) data strobe active low
            strobe_on = ~st;
        end
    endfunction

    // Access is a read for the current style
    function automatic logic is_read(input logic sty, input logic rd);
        // (RL6) direction high reads
        if (sty == QLH_STROBE_DIR) begin
            is_read = rd;
        end else begin
            is_read = ~rd;
        end
    endfunction

    // ******************************************************
    // Address phase
    // ******************************************************
    logic [INDEX_W-1:0]  mux_index;
    logic [DEV_W-1:0]    mux_dev;
    logic                selected;
    logic [INDEX_W-1:0]  cur_index;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mux_index <= '0;
            mux_dev   <= '0;
        end else if (ce && share && latch_s) begin
            // (RL10) low nibble is index
            mux_index <= ad_s[INDEX_W-1:0];
            mux_dev   <= ad_s[6:4];
        end
    end

    // (RL3) shared bus address
    // (RL5) shared bus with strobes
    assign cur_index = share ? mux_index : addr_s;
    // (RL11) internal select match
    assign selected = ~cs_n_s & (~share | ~dev_addr_strap[3]
                      | (mux_dev == dev_addr_strap[DEV_W-1:0]));

    // ******************************************************
    // Access sequencer
    // ******************************************************
    qlh_dev_state_t      state;
    logic                read_q;
    logic [DATA_W-1:0]   rdata_q;
    logic                active;

    assign active = strobe_on(style, store_s, rdir_s);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state     <= D_IDLE;
            read_q    <= 1'b0;
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
            reg_index <= '0;
            reg_wdata <= '0;
        end else if (ce) begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            case (state)
                D_IDLE: begin
                    if (selected && active) begin
                        reg_index <= cur_index;
                        read_q    <= is_read(style, rdir_s);
                        if (is_read(style, rdir_s)) begin
                            reg_rd <= 1'b1;
                            state  <= D_FETCH;
                        end else begin
                            reg_wr    <= 1'b1;
                            reg_wdata <= ad_s;
                            state     <= D_ACK;
                        end
                    end
                end
                D_FETCH: begin
                    state <= D_ACK;
                end
                D_ACK: begin
                    if (!active || cs_n_s) begin
                        state <= D_IDLE;
                    end
                end
                default: begin
                    state <= D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (ce && state == D_FETCH) begin
            rdata_q <= reg_rdata;
        end
    end

    // ******************************************************
    // Pin drivers
    // ******************************************************
    logic                out_step;

    // Done and interrupt outputs follow host clock edges when aligned; the bus data outputs do not
    assign out_step = ~align_host_clock | hclk_rise;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus.ad_dev_o  <= '0;
            bus.ad_dev_oe <= 1'b0;
        end else if (ce) begin
            bus.ad_dev_o  <= rdata_q;
            // (RL12) drive only selected read
            bus.ad_dev_oe <= (state == D_ACK) & read_q & active & ~cs_n_s;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus.done_o  <= 1'b0;
            bus.done_oe <= 1'b0;
            bus.irq     <= 1'b0;
        end else if (ce && out_step) begin
            // (RL7) shared done pin meaning
            if (style == QLH_RD_WR) begin
                // (RL8) ready high on completion
                bus.done_o <= (state == D_ACK);
            end else begin
                // (RL9) acknowledge low on completion
                bus.done_o <= ~(state == D_ACK);
            end
            // (RL8) floats while deselected
            bus.done_oe <= ~cs_n_s;
            // (RL7) interrupt active high
            bus.irq     <= alarm_irq;
        end
    end

endmodule // qlh_device

// >>> verilog/qlh_pkg.sv
// Shared constants and types of the quad line host bus port
package qlh_pkg;

    // ******************************************************
    // Widths
    // ******************************************************
    localparam int DATA_W = 8;
    localparam int INDEX_W = 4;
    localparam int DEV_W = 3;

    // ******************************************************
    // Pin reset values
    // ******************************************************
    // Order: style, share, cs_n, latch, store, read/dir
    localparam logic [5:0] DEV_CTL_RESET = 6'h0B;
    // Order: style, share, done, irq, host clock
    localparam logic [4:0] HOST_CTL_RESET = 5'h04;
    localparam logic [7:0] AD_IDLE = 8'hFF;

    // ******************************************************
    // Host register map, Avalon byte addresses
    // ******************************************************
    localparam logic [3:0] CMD_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS = 4'hC;

    // ******************************************************
    // Host register fields
    // ******************************************************
    localparam int CMD_WDATA_LSB = 0;
    localparam int CMD_INDEX_LSB = 8;
    localparam int CMD_DEV_LSB = 12;
    localparam int CMD_READ_BIT = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RDATA_LSB = 8;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_DEV_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    // ******************************************************
    // Host timing in clk cycles
    // ******************************************************
    localparam logic [1:0] ADDR_PHASE_CYCLES = 2'h2;

    typedef enum logic {QLH_STROBE_DIR, QLH_RD_WR} qlh_style_t;

endpackage

// >>> verilog/qlh_bus_if.sv
// Shared host pins between host end and device end
`timescale 1ns/1ps
interface qlh_bus_if;
    import qlh_pkg::*;

    // Straps and host clock, driven by the board
    logic                bus_style_select;
    logic                addr_data_share_select;
    logic                host_clock;
    // Host driven pins
    logic                cs_n;
    logic                latch_or_strobe_pin;
    logic                store_or_strobe_pin;
    logic                read_or_dir_pin;
    logic [INDEX_W-1:0]  addr;
    logic [DATA_W-1:0]   ad_host_o;
    logic                ad_host_oe;
    // Device driven pins
    logic [DATA_W-1:0]   ad_dev_o;
    logic                ad_dev_oe;
    logic                done_o;
    logic                done_oe;
    logic                irq;
    // Resolved wire levels
    logic [DATA_W-1:0]   ad;
    logic                done_pin;

    // Pull-up on the bus, inactive level on a floating done pin
    assign ad = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : AD_IDLE);
    assign done_pin = done_oe ? done_o : ~bus_style_select;

    modport device (
        input  bus_style_select, addr_data_share_select, host_clock,
        input  cs_n, latch_or_strobe_pin, store_or_strobe_pin, read_or_dir_pin,
        input  addr, ad,
        output ad_dev_o, ad_dev_oe, done_o, done_oe, irq
    );

    modport host (
        input  bus_style_select, addr_data_share_select, host_clock,
        output cs_n, latch_or_strobe_pin, store_or_strobe_pin, read_or_dir_pin,
        output addr, ad_host_o, ad_host_oe,
        input  ad, done_pin, irq
    );

endinterface

// >>> verilog/qlh_host.sv
// Host end of the quad line host bus port with Avalon-MM control
`timescale 1ns/1ps
module qlh_host
    import qlh_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    // Avalon-MM slave
    input  wire logic [3:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic [31:0]       avs_readdata,
    output logic              avs_waitrequest,
    output logic              irq,
    // Host pins
    qlh_bus_if.host           bus
);

    typedef enum logic [2:0] {H_IDLE, H_ADDR, H_HOLD, H_STROBE, H_RELEASE} qlh_host_state_t;

    // ******************************************************
    // Pin synchronisers
    // ******************************************************
    logic [4:0]         ctl_meta;
    logic [4:0]         ctl_s;
    logic [DATA_W-1:0]  ad_meta;
    logic [DATA_W-1:0]  ad_s;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctl_meta <= HOST_CTL_RESET;
            ctl_s    <= HOST_CTL_RESET;
            ad_meta  <= AD_IDLE;
            ad_s     <= AD_IDLE;
        end else if (ce) begin
            ctl_meta <= {bus.bus_style_select, bus.addr_data_share_select, bus.done_pin,
                         bus.irq, bus.host_clock};
            ctl_s    <= ctl_meta;
            ad_meta  <= bus.ad;
            ad_s     <= ad_meta;
        end
    end

    logic  style;
    logic  share;
    logic  done_on;
    logic  dev_irq;
    logic  dev_irq_q;

    assign style   = ctl_s[4];
    assign share   = ctl_s[3];
    // (RL8) ready high, (RL9) acknowledge low
    assign done_on = (style == QLH_RD_WR) ? ctl_s[2] : ~ctl_s[2];
    assign dev_irq = ctl_s[1];

    // ******************************************************
    // Avalon slave
    // ******************************************************
    qlh_host_state_t     state;
    logic                rvalid;
    logic                start;
    logic                done_evt;
    logic [1:0]          irq_stat;
    logic [1:0]          irq_mask;
    logic [DATA_W-1:0]   rdata;
    logic [16:0]         cmd;

    assign start = avs_write & (avs_address == CMD_OFS) & (state == H_IDLE) & ce;
    assign avs_waitrequest = (avs_read & ~rvalid)
                             | (avs_write & (avs_address == CMD_OFS) & (state != H_IDLE))
                             | ~ce;
    assign irq = |(irq_stat & irq_mask);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rvalid       <= 1'b0;
            avs_readdata <= '0;
        end else if (ce) begin
            rvalid <= avs_read & ~rvalid;
            case (avs_address)
                CMD_OFS:      avs_readdata <= {15'h0000, cmd};
                STAT_OFS:     avs_readdata <= {16'h0000, rdata, 7'h00, state != H_IDLE};
                IRQ_STAT_OFS: avs_readdata <= {30'h00000000, irq_stat};
                IRQ_MASK_OFS: avs_readdata <= {30'h00000000, irq_mask};
                default:      avs_readdata <= '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_mask <= IRQ_MASK_RESET;
            irq_stat <= 2'h0;
            dev_irq_q <= 1'b0;
        end else if (ce) begin
            dev_irq_q <= dev_irq;
            if (avs_write && avs_address == IRQ_MASK_OFS) begin
                irq_mask <= avs_writedata[1:0];
            end
            // Set wins over write-one clear
            irq_stat <= (irq_stat & ~((avs_write && avs_address == IRQ_STAT_OFS)
                         ? avs_writedata[1:0] : 2'h0))
                        | {dev_irq & ~dev_irq_q, done_evt};
        end
    end

    // ******************************************************
    // Pin sequencer
    // ******************************************************
    logic [1:0]  cnt;
    logic        rd;

    assign rd = cmd[CMD_READ_BIT];

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state                   <= H_IDLE;
            cmd                     <= '0;
            cnt                     <= '0;
            rdata                   <= '0;
            done_evt                <= 1'b0;
            bus.cs_n                <= 1'b1;
            bus.latch_or_strobe_pin <= 1'b0;
            bus.store_or_strobe_pin <= 1'b1;
            bus.read_or_dir_pin     <= 1'b1;
            bus.addr                <= '0;
            bus.ad_host_o           <= '0;
            bus.ad_host_oe          <= 1'b0;
        end else if (ce) begin
            done_evt <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (start) begin
                        cmd      <= avs_writedata[16:0];
                        bus.addr <= avs_writedata[CMD_INDEX_LSB +: INDEX_W];
                        if (share) begin
                            // (RL3) address phase on shared bus
                            bus.ad_host_o <= {1'b0, avs_writedata[CMD_DEV_LSB +: DEV_W],
                                              avs_writedata[CMD_INDEX_LSB +: INDEX_W]};
                            bus.ad_host_oe          <= 1'b1;
                            bus.latch_or_strobe_pin <= 1'b1;
                            cnt                     <= ADDR_PHASE_CYCLES;
                            state                   <= H_ADDR;
                        end else begin
                            state <= H_HOLD;
                        end
                    end
                end
                H_ADDR: begin
                    cnt <= cnt - 2'h1;
                    if (cnt == 2'h1) begin
                        bus.latch_or_strobe_pin <= 1'b0;
                        state                   <= H_HOLD;
                    end
                end
                H_HOLD: begin
                    bus.ad_host_o  <= cmd[CMD_WDATA_LSB +: DATA_W];
                    bus.ad_host_oe <= ~rd;
                    bus.cs_n       <= 1'b0;
                    // (RL1) strobes by style
                    if (style == QLH_RD_WR) begin
                        bus.store_or_strobe_pin <= rd;
                        bus.read_or_dir_pin     <= ~rd;
                    end else begin
                        // (RL6) direction high reads
                        bus.store_or_strobe_pin <= 1'b0;
                        bus.read_or_dir_pin     <= rd;
                    end
                    state <= H_STROBE;
                end
                H_STROBE: begin
                    if (done_on) begin
                        rdata                   <= rd ? ad_s : rdata;
                        bus.cs_n                <= 1'b1;
                        bus.store_or_strobe_pin <= 1'b1;
                        bus.read_or_dir_pin     <= 1'b1;
                        bus.ad_host_oe          <= 1'b0;
                        state                   <= H_RELEASE;
                    end
                end
                H_RELEASE: begin
                    if (!done_on) begin
                        done_evt <= 1'b1;
                        state    <= H_IDLE;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

endmodule // qlh_host

// >>> sim/qlh_checker.sv
// Assertions on the shared host pins
`timescale 1ns/1ps
module qlh_checker (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    // Pins
    input wire logic       bus_style_select,
    input wire logic       addr_data_share_select,
    input wire logic       cs_n,
    input wire logic       latch_or_strobe_pin,
    input wire logic       store_or_strobe_pin,
    input wire logic       read_or_dir_pin,
    input wire logic [7:0] ad,
    input wire logic       ad_host_oe,
    input wire logic       ad_dev_oe,
    input wire logic       done_oe,
    input wire logic       done_pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic strb;
    logic done_act;
    logic alat;
    logic no_read;
    assign no_read = cs_n | (read_or_dir_pin == bus_style_select);
    assign strb = ~store_or_strobe_pin | (bus_style_select & ~read_or_dir_pin);
    assign done_act = done_oe & (done_pin == bus_style_select);
    assign alat = latch_or_strobe_pin & addr_data_share_select;
    // ****
    // Checks
    // ****
    a_done_float: assert property (cs_n [*6] |-> !done_oe)
        else $error("done driven while deselected");
    a_bus_idle: assert property (no_read [*6] |-> !ad_dev_oe)
        else $error("bus driven outside a read");
    a_no_clash: assert property (!(ad_dev_oe && ad_host_oe))
        else $error("both ends drive the bus");
    a_done_cause: assert property ((!strb || cs_n) [*6] |-> !done_act)
        else $error("done without a strobe");
    a_done_time: assert property ($rose(strb && !cs_n) |-> ##[1:16] done_act)
        else $error("no completion in time");
    a_done_hold: assert property (done_act && strb && !cs_n |=> done_act)
        else $error("done dropped early");
    a_addr_phase: assert property ($rose(alat) |-> alat [*2] ##1 !alat)
        else $error("address phase length");
    a_addr_held: assert property ($rose(alat) |-> !ad[7] ##1 $stable(ad) [*2])
        else $error("address not held");
    cover property ($rose(done_act) && bus_style_select);
    cover property ($rose(done_act) && !bus_style_select);
    cover property (ad_dev_oe && addr_data_share_select);
endmodule // qlh_checker

// >>> sim/tb_top.sv
// Bench joining host and device ends
`timescale 1ns/1ps
module tb_top;
    import qlh_pkg::*;
    logic        clk;
    logic        resetn;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    logic        alarm_irq;
    logic        align;
    logic        reg_wr;
    logic        reg_rd;
    logic [3:0]  reg_index;
    logic [7:0]  reg_wdata;
    logic [3:0]  dev_addr_strap;
    logic [3:0]  idx;
    logic [7:0]  bank [16];
    logic [12:0] exp_q [$];
    logic [31:0] q;
    int          error_cnt;
    int          total_checks;
    qlh_bus_if bus ();
    qlh_host u_qlh_host (.clk(clk), .resetn(resetn), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .bus(bus));
    qlh_device u_qlh_device (.clk(clk), .resetn(resetn), .ce(1'b1), .bus(bus),
        .dev_addr_strap(dev_addr_strap), .align_host_clock(align), .alarm_irq(alarm_irq),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index), .reg_wdata(reg_wdata),
        .reg_rdata(bank[reg_index]));
    qlh_checker u_qlh_checker (.clk(clk), .resetn(resetn),
        .bus_style_select(bus.bus_style_select),
        .addr_data_share_select(bus.addr_data_share_select), .cs_n(bus.cs_n),
        .latch_or_strobe_pin(bus.latch_or_strobe_pin),
        .store_or_strobe_pin(bus.store_or_strobe_pin), .read_or_dir_pin(bus.read_or_dir_pin),
        .ad(bus.ad), .ad_host_oe(bus.ad_host_oe), .ad_dev_oe(bus.ad_dev_oe),
        .done_oe(bus.done_oe), .done_pin(bus.done_pin));
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk);
        avs_write <= w;
        avs_read <= ~w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic acc(input logic rd, input logic [3:0] i, input logic [2:0] id);
        logic [7:0] d;
        logic [7:0] e;
        d = 8'($urandom);
        e = bank[i];
        exp_q.push_back({rd, i, rd ? 8'h00 : d});
        av(1'b1, CMD_OFS, {15'h0, rd, 1'b0, id, i, d}, q);
        q = 32'h1;
        while (q[STAT_BUSY_BIT] !== 1'b0)
            av(1'b0, STAT_OFS, 32'h0, q);
        if (rd)
            chk(q[15:8], e);
        av(1'b0, IRQ_STAT_OFS, 32'h0, q);
        chk(q[IRQ_DONE_BIT], 1'b1);
        av(1'b1, IRQ_STAT_OFS, 32'h1, q);
    endtask
    // ****
    // Clock, watchdog, monitor
    // ****
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        bus.host_clock <= align & ~bus.host_clock;
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    always @(posedge clk) begin
        if (reg_wr || reg_rd)
            chk({reg_rd, reg_index, reg_rd ? 8'h00 : reg_wdata}, exp_q.pop_front());
        if (reg_wr)
            bank[reg_index] <= reg_wdata;
    end
    // ****
    // Sequence
    // ****
    initial begin
        void'($urandom(32'h2142));
        error_cnt = 0;
        total_checks = 0;
        resetn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        alarm_irq = 1'b0;
        dev_addr_strap = 4'h0;
        bus.bus_style_select = 1'b0;
        bus.addr_data_share_select = 1'b0;
        align = 1'b0;
        foreach (bank[i])
            bank[i] = 8'($urandom);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        av(1'b0, IRQ_MASK_OFS, 32'h0, q);
        chk(q[1:0], IRQ_MASK_RESET);
        av(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0);
        for (int m = 0; m < 4; m++) begin
            bus.bus_style_select <= m[1];
            bus.addr_data_share_select <= m[0];
            dev_addr_strap <= {m[0], 3'(m + 3)};
            align <= m[0];
            repeat (4) @(posedge clk);
            for (int k = 0; k < 3; k++) begin
                idx = 4'($urandom);
                acc(1'b0, idx, 3'(m + 3));
                acc(1'b1, idx, 3'(m + 3));
            end
        end
        alarm_irq <= 1'b1;
        q = 32'h0;
        while (q[IRQ_DEV_BIT] !== 1'b1)
            av(1'b0, IRQ_STAT_OFS, 32'h0, q);
        chk({bus.irq, irq}, 2'h2);
        av(1'b1, IRQ_MASK_OFS, 32'h2, q);
        @(posedge clk);
        chk(irq, 1'b1);
        av(1'b1, IRQ_STAT_OFS, 32'h2, q);
        @(posedge clk);
        chk(irq, 1'b0);
        alarm_irq <= 1'b0;
        give_verdict();
    end
endmodule // tb_top
